// ==== hw/boot_sel_regs.svh ====
/*
 * offsets, field positions, encodings and flash word addresses of the boot mode selector.
 * assumes a 16-bit register port and 16-bit flash words.
 */
`ifndef BOOT_SEL_REGS_SVH
`define BOOT_SEL_REGS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define BOOT_MODE_STATUS_ADDR   16'hFE0A
`define BOOT_SEL_RESULT_ADDR    16'hFE0C
`define ALT_FLAG_BIT            5

// ---------------------------------------------------------------
// strap encodings on port0 low bits 5..4
// ---------------------------------------------------------------
`define STRAP_NORMAL            2'h3
`define STRAP_STD_BOOT          2'h2
`define STRAP_ALT_BOOT          2'h1

// ---------------------------------------------------------------
// flash word addresses (word byte addresses, 24 bits)
// ---------------------------------------------------------------
`define USER_OP0_ADDR           24'h000000
`define USER_OP1_ADDR           24'h001FFC
`define USER_REF_ADDR           24'h001FFE
`define ALT_OP0_ADDR            24'h090000
`define ALT_OP1_ADDR            24'h091FFC
`define ALT_REF_ADDR            24'h091FFE

// ---------------------------------------------------------------
// selective boot word values
// ---------------------------------------------------------------
`define SEL_ALL_ZERO            16'h0000
`define SEL_ALL_ONE             16'hFFFF
`define SEL_UART_ONLY           8'h01
`define SEL_CAN_ONLY            8'h02
`define SEL_BOTH                8'h03

`endif

// ==== hw/boot_sel_pkg.sv ====
/*
 * types of the boot mode selector.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package boot_sel_pkg;

	// outcome of the reset-time decision
	typedef enum logic [2:0] {
		BOOT_PENDING,
		BOOT_NORMAL,
		BOOT_STANDARD,
		BOOT_ALT_USER,
		BOOT_ALT_ALT,
		BOOT_SELECTIVE,
		BOOT_TEST_LOOP,
		BOOT_TEST_MODE
	} boot_outcome_t;

	// flash read request
	typedef struct packed {
		logic        req;
		logic [23:0] addr;
	} flash_req_t;

	// flash read answer
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} flash_rsp_t;

	// register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

endpackage

// ==== hw/strap_sync.sv ====
/*
 * three-stage synchroniser for pin inputs; a change is taken once stages two
 * and three agree.
 * assumes an asynchronous active-low reset and inputs from outside the domain.
 */
`timescale 1ns/10ps

module strap_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	// pins
	input  wire logic [WIDTH-1:0] i_async,
	// synchronised value
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	// accept a bit only when the two trailing stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			out_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : out_q[i];
		end
	end

	// shift chain
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q  <= i_async;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign o_sync = out_q;

endmodule

// ==== hw/boot_mode_select.sv ====
/*
 * reset-time boot mode selector: latches the straps at the release of the
 * reset pin, decodes them, runs the flash signature checks and the selective
 * boot decision, and shows the alternate-boot flag in the status register.
 * assumes a flash read port that answers each request with one valid pulse,
 * and strap and reset pins that come from outside the clock domain.
 */
// The strobed register port was left to the implementer.
// Behaviour
// - latch strap bits at reset pin rise
// - straps 11 give normal reset
// - straps 10 start bootstrap, clear alternate indicator
// - straps 01 enter alternate boot via signatures
// - other straps select internal test modes
// - sum operands, invert low byte, compare reference
// - status bit 5 shows alternate boot
// - flag read-only until next reset
// - no signature: 0000 or FFFF means bootstrap
// - low bit0 watches uart, bit1 can
// - 03 both, 01 uart, 02 can, else loop
// - alternate boot left only by reset
`timescale 1ns/10ps
`include "boot_sel_regs.svh"

module boot_mode_select (
	// clock and reset
	input  wire logic                       i_clock,
	input  wire logic                       i_nrst,
	input  wire logic                       i_soft_reset,
	// pins
	input  wire logic                       i_reset_input_pin,
	input  wire logic [1:0]                 i_port0_low_straps,
	// flash read port
	output boot_sel_pkg::flash_req_t        o_flash,
	input  wire boot_sel_pkg::flash_rsp_t   i_flash,
	// register port
	input  wire boot_sel_pkg::reg_req_t     i_reg,
	output logic [15:0]                     o_rdata,
	// decision
	output boot_sel_pkg::boot_outcome_t     o_outcome,
	output logic                            o_done,
	output logic                            o_uart_watch,
	output logic                            o_can_watch,
	output logic                            o_alternate_boot_flag
);

	// ---------------------------------------------------------------
	// types and helpers
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_WAIT_PIN,
		ST_DECODE,
		ST_READ_OP0,
		ST_READ_OP1,
		ST_READ_REF,
		ST_CHECK,
		ST_READ_SEL,
		ST_SELECT,
		ST_DONE
	} seq_state_t;

	// signature of two operands
	function automatic logic [15:0] signature(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] sum;
		sum = a + b;
		return {sum[15:8], ~sum[7:0]};
	endfunction

	// flash address of word n of the current check set
	function automatic logic [23:0] set_addr(input logic alt_set, input logic [1:0] n);
		logic [23:0] a;
		a = 24'h000000;
		case (n)
			2'h0: a = alt_set ? `ALT_OP0_ADDR : `USER_OP0_ADDR;
			2'h1: a = alt_set ? `ALT_OP1_ADDR : `USER_OP1_ADDR;
			default: a = alt_set ? `ALT_REF_ADDR : `USER_REF_ADDR;
		endcase
		return a;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] pins_sync;

	strap_sync #(
		.WIDTH(3)
	) u_sync (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_async ({i_reset_input_pin, i_port0_low_straps}),
		.o_sync  (pins_sync)
	);

	wire logic       pin_level = pins_sync[2];
	wire logic [1:0] straps    = pins_sync[1:0];

	// ---------------------------------------------------------------
	// sequencer state
	// ---------------------------------------------------------------
	seq_state_t                  state_q, state_d;
	logic                        pin_prev_q, pin_prev_d;
	logic [1:0]                  cfg_q, cfg_d;
	logic                        alt_set_q, alt_set_d;
	logic [15:0]                 op0_q, op0_d;
	logic [15:0]                 op1_q, op1_d;
	logic [15:0]                 ref_q, ref_d;
	logic                        req_q, req_d;
	logic [23:0]                 addr_q, addr_d;
	boot_sel_pkg::boot_outcome_t outcome_q, outcome_d;
	logic                        done_q, done_d;
	logic                        uart_q, uart_d;
	logic                        can_q, can_d;
	logic                        alt_flag_q, alt_flag_d;
	logic [15:0]                 rdata_q, rdata_d;

	wire logic pin_rise = pin_level && !pin_prev_q;

	// next state of the reset-time sequence
	always_comb begin
		state_d    = state_q;
		pin_prev_d = pin_level;
		cfg_d      = cfg_q;
		alt_set_d  = alt_set_q;
		op0_d      = op0_q;
		op1_d      = op1_q;
		ref_d      = ref_q;
		req_d      = 1'b0;
		addr_d     = addr_q;
		outcome_d  = outcome_q;
		done_d     = done_q;
		uart_d     = uart_q;
		can_d      = can_q;
		alt_flag_d = alt_flag_q;
		case (state_q)
			ST_WAIT_PIN: begin
				if (pin_rise) begin
					cfg_d   = straps;
					state_d = ST_DECODE;
				end
			end
			ST_DECODE: begin
				alt_set_d = 1'b0;
				case (cfg_q)
					`STRAP_NORMAL: begin
						outcome_d = boot_sel_pkg::BOOT_NORMAL;
						state_d   = ST_DONE;
					end
					`STRAP_STD_BOOT: begin
						outcome_d  = boot_sel_pkg::BOOT_STANDARD;
						alt_flag_d = 1'b0;
						state_d    = ST_DONE;
					end
					`STRAP_ALT_BOOT: begin
						alt_flag_d = 1'b1;
						req_d      = 1'b1;
						addr_d     = set_addr(1'b0, 2'h0);
						state_d    = ST_READ_OP0;
					end
					default: begin
						outcome_d = boot_sel_pkg::BOOT_TEST_MODE;
						state_d   = ST_DONE;
					end
				endcase
			end
			ST_READ_OP0: begin
				if (i_flash.valid) begin
					op0_d   = i_flash.data;
					req_d   = 1'b1;
					addr_d  = set_addr(alt_set_q, 2'h1);
					state_d = ST_READ_OP1;
				end
			end
			ST_READ_OP1: begin
				if (i_flash.valid) begin
					op1_d   = i_flash.data;
					req_d   = 1'b1;
					addr_d  = set_addr(alt_set_q, 2'h2);
					state_d = ST_READ_REF;
				end
			end
			ST_READ_REF: begin
				if (i_flash.valid) begin
					ref_d   = i_flash.data;
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (signature(op0_q, op1_q) == ref_q) begin
					outcome_d = alt_set_q ? boot_sel_pkg::BOOT_ALT_ALT
					                      : boot_sel_pkg::BOOT_ALT_USER;
					state_d   = ST_DONE;
				end else if (!alt_set_q) begin
					alt_set_d = 1'b1;
					req_d     = 1'b1;
					addr_d    = set_addr(1'b1, 2'h0);
					state_d   = ST_READ_OP0;
				end else begin
					req_d   = 1'b1;
					addr_d  = `USER_OP1_ADDR;
					state_d = ST_READ_SEL;
				end
			end
			ST_READ_SEL: begin
				if (i_flash.valid) begin
					op1_d   = i_flash.data;
					state_d = ST_SELECT;
				end
			end
			ST_SELECT: begin
				state_d = ST_DONE;
				if (op1_q == `SEL_ALL_ZERO || op1_q == `SEL_ALL_ONE) begin
					outcome_d = boot_sel_pkg::BOOT_STANDARD;
				end else begin
					case (op1_q[7:0])
						`SEL_BOTH: begin
							outcome_d = boot_sel_pkg::BOOT_SELECTIVE;
							uart_d    = 1'b1;
							can_d     = 1'b1;
						end
						`SEL_UART_ONLY: begin
							outcome_d = boot_sel_pkg::BOOT_SELECTIVE;
							uart_d    = 1'b1;
						end
						`SEL_CAN_ONLY: begin
							outcome_d = boot_sel_pkg::BOOT_SELECTIVE;
							can_d     = 1'b1;
						end
						default: outcome_d = boot_sel_pkg::BOOT_TEST_LOOP;
					endcase
				end
			end
			ST_DONE: begin
				done_d = 1'b1;
			end
			default: state_d = ST_WAIT_PIN;
		endcase
	end

	// sequence registers; software reset restarts the decision and clears the flag
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q    <= ST_WAIT_PIN;
			pin_prev_q <= 1'b1;
			cfg_q      <= 2'h0;
			alt_set_q  <= 1'b0;
			op0_q      <= 16'h0000;
			op1_q      <= 16'h0000;
			ref_q      <= 16'h0000;
			req_q      <= 1'b0;
			addr_q     <= 24'h000000;
			outcome_q  <= boot_sel_pkg::BOOT_PENDING;
			done_q     <= 1'b0;
			uart_q     <= 1'b0;
			can_q      <= 1'b0;
			alt_flag_q <= 1'b0;
		end else if (i_soft_reset) begin
			state_q    <= ST_DECODE;
			pin_prev_q <= pin_level;
			cfg_q      <= cfg_q;
			alt_set_q  <= 1'b0;
			op0_q      <= 16'h0000;
			op1_q      <= 16'h0000;
			ref_q      <= 16'h0000;
			req_q      <= 1'b0;
			addr_q     <= 24'h000000;
			outcome_q  <= boot_sel_pkg::BOOT_PENDING;
			done_q     <= 1'b0;
			uart_q     <= 1'b0;
			can_q      <= 1'b0;
			alt_flag_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			pin_prev_q <= pin_prev_d;
			cfg_q      <= cfg_d;
			alt_set_q  <= alt_set_d;
			op0_q      <= op0_d;
			op1_q      <= op1_d;
			ref_q      <= ref_d;
			req_q      <= req_d;
			addr_q     <= addr_d;
			outcome_q  <= outcome_d;
			done_q     <= done_d;
			uart_q     <= uart_d;
			can_q      <= can_d;
			alt_flag_q <= alt_flag_d;
		end
	end

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	// read data one cycle after the strobe; writes change nothing
	always_comb begin
		rdata_d = 16'h0000;
		if (i_reg.rd) begin
			case (i_reg.addr)
				`BOOT_MODE_STATUS_ADDR: rdata_d[`ALT_FLAG_BIT] = alt_flag_q;
				`BOOT_SEL_RESULT_ADDR:  rdata_d = {8'h00, done_q, can_q, uart_q,
				                                   2'h0, outcome_q};
				default:                rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_flash.req           = req_q;
	assign o_flash.addr          = addr_q;
	assign o_rdata               = rdata_q;
	assign o_outcome             = outcome_q;
	assign o_done                = done_q;
	assign o_uart_watch          = uart_q;
	assign o_can_watch           = can_q;
	assign o_alternate_boot_flag = alt_flag_q;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst || i_soft_reset);

	sequence s_rise_with(logic [1:0] v);
		pin_rise && straps == v;
	endsequence

	AST_LATCH: assert property (pin_rise && state_q == ST_WAIT_PIN |=> cfg_q == $past(straps))
		else $error("straps not latched at pin rise");
	AST_NORMAL: assert property (state_q == ST_WAIT_PIN ##0 s_rise_with(2'h3)
		|-> ##3 outcome_q == boot_sel_pkg::BOOT_NORMAL && !alt_flag_q)
		else $error("normal straps gave wrong outcome");
	AST_STD: assert property (state_q == ST_WAIT_PIN ##0 s_rise_with(2'h2)
		|-> ##3 outcome_q == boot_sel_pkg::BOOT_STANDARD && !alt_flag_q)
		else $error("bootstrap straps gave wrong outcome");
	AST_ALT: assert property (state_q == ST_DECODE && cfg_q == 2'h1
		|=> req_q && addr_q == 24'h000000 && alt_flag_q)
		else $error("alternate boot did not start user check");
	AST_TEST: assert property (state_q == ST_DECODE && cfg_q == 2'h0
		|=> outcome_q == boot_sel_pkg::BOOT_TEST_MODE)
		else $error("test straps gave wrong outcome");
	AST_SIG: assert property (state_q == ST_CHECK
		&& ref_q == {op0_q[15:8] + op1_q[15:8] + 8'((9'(op0_q[7:0]) + 9'(op1_q[7:0])) >> 8),
		             ~(op0_q[7:0] + op1_q[7:0])}
		|=> state_q == ST_DONE)
		else $error("good signature not accepted");
	AST_FLAG: assert property (alt_flag_q && !i_soft_reset |=> alt_flag_q)
		else $error("alternate flag dropped without reset");
	AST_FALLBACK: assert property (state_q == ST_SELECT && (op1_q == 16'h0000 || op1_q == 16'hFFFF)
		|=> outcome_q == boot_sel_pkg::BOOT_STANDARD && !uart_q && !can_q)
		else $error("blank selective word did not fall back");
	AST_SELECT: assert property (state_q == ST_SELECT && op1_q != 16'h0000 && op1_q != 16'hFFFF
		|=> uart_q == (op1_q[7:0] inside {8'h01, 8'h03})
		 && can_q == (op1_q[7:0] inside {8'h02, 8'h03}))
		else $error("selective channels wrong");
	AST_STAY: assert property (done_q && !i_soft_reset |=> done_q && $stable(outcome_q))
		else $error("decision changed after completion");

endmodule

// ==== test/flash_model.sv ====
/*
 * far-side model of the boot selector: on-chip flash words answering reads
 * after a set delay.
 * assumes one outstanding read at a time and words set by the testbench.
 */
`timescale 1ns/10ps

module flash_model (
	// clock and reset
	input  wire logic                     i_clock,
	input  wire logic                     i_nrst,
	// contents and answer delay
	input  wire logic [5:0][15:0]         i_mem,
	input  wire logic [3:0]               i_delay,
	// flash read port
	input  wire boot_sel_pkg::flash_req_t i_req,
	output boot_sel_pkg::flash_rsp_t      o_rsp
);
	logic [15:0] word_d;
	logic [15:0] hold_q;
	logic [3:0]  wait_q;
	logic        busy_q;

	// ------------------------------------------------------------
	// word lookup
	// ------------------------------------------------------------
	// signature words in two segments, erased flash everywhere else
	always_comb begin
		case (i_req.addr)
			24'h000000: word_d = i_mem[0];
			24'h001FFC: word_d = i_mem[1];
			24'h001FFE: word_d = i_mem[2];
			24'h090000: word_d = i_mem[3];
			24'h091FFC: word_d = i_mem[4];
			24'h091FFE: word_d = i_mem[5];
			default:    word_d = 16'hFFFF;
		endcase
	end

	// ------------------------------------------------------------
	// answer
	// ------------------------------------------------------------
	// data toggles outside the valid pulse so stale values never match
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
			hold_q <= 16'h0;
			o_rsp  <= '{valid: 1'b0, data: 16'h0};
		end else if (i_req.req) begin
			busy_q      <= 1'b1;
			wait_q      <= i_delay;
			hold_q      <= word_d;
			o_rsp.valid <= 1'b0;
			o_rsp.data  <= ~o_rsp.data;
		end else if (busy_q && wait_q == 4'h0) begin
			busy_q <= 1'b0;
			o_rsp  <= '{valid: 1'b1, data: hold_q};
		end else begin
			wait_q      <= wait_q - 4'h1;
			o_rsp.valid <= 1'b0;
			o_rsp.data  <= ~o_rsp.data;
		end
	end
endmodule

// ==== test/tb.sv ====
/*
 * self-checking testbench of the boot mode selector.
 * assumes the flash model beside it and the register map header.
 */
`timescale 1ns/10ps
`include "boot_sel_regs.svh"

module tb;
	localparam logic [15:0] SEL_WORD [6] = '{16'h0000, 16'hFFFF, 16'h1203,
		16'hAB01, 16'h0002, 16'h0004};
	localparam boot_sel_pkg::boot_outcome_t SEL_OUT [6] = '{boot_sel_pkg::BOOT_STANDARD,
		boot_sel_pkg::BOOT_STANDARD, boot_sel_pkg::BOOT_SELECTIVE,
		boot_sel_pkg::BOOT_SELECTIVE, boot_sel_pkg::BOOT_SELECTIVE,
		boot_sel_pkg::BOOT_TEST_LOOP};
	localparam logic [2:0] SEL_WF [6] = '{3'h1, 3'h1, 3'h7, 3'h5, 3'h3, 3'h1};

	logic                        clock      = 1'b0;
	logic                        nrst       = 1'b0;
	logic                        soft_reset = 1'b0;
	logic                        pin        = 1'b0;
	logic [1:0]                  straps     = 2'h3;
	logic [5:0][15:0]            mem        = '0;
	logic [3:0]                  delay      = 4'h0;
	boot_sel_pkg::reg_req_t      bus        = '0;
	boot_sel_pkg::flash_req_t    flash_req;
	boot_sel_pkg::flash_rsp_t    flash_rsp;
	boot_sel_pkg::boot_outcome_t outcome;
	logic [15:0]                 rdata;
	logic [15:0]                 d;
	logic                        done;
	logic                        uart_w;
	logic                        can_w;
	logic                        flag;
	int                          fail_count = 0;
	int                          cmp_count  = 0;

	// ------------------------------------------------------------
	// clock and instances
	// ------------------------------------------------------------
	always #4 clock = ~clock;

	boot_mode_select uut (.i_clock(clock), .i_nrst(nrst), .i_soft_reset(soft_reset),
		.i_reset_input_pin(pin), .i_port0_low_straps(straps), .o_flash(flash_req),
		.i_flash(flash_rsp), .i_reg(bus), .o_rdata(rdata), .o_outcome(outcome),
		.o_done(done), .o_uart_watch(uart_w), .o_can_watch(can_w),
		.o_alternate_boot_flag(flag));

	flash_model flash (.i_clock(clock), .i_nrst(nrst), .i_mem(mem), .i_delay(delay),
		.i_req(flash_req), .o_rsp(flash_rsp));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// reference signature: 16-bit sum, low byte inverted
	function automatic logic [15:0] sig(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] s;
		s = a + b;
		return {s[15:8], ~s[7:0]};
	endfunction

	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// compares decision, watches and flag, then closes the test
	task automatic chk_boot(input boot_sel_pkg::boot_outcome_t exp, input logic [2:0] wf);
		cmp_count++;
		if (outcome !== exp || {uart_w, can_w, flag} !== wf) begin
			fail_count++;
			$display("wrong value at %0t: outcome %0d watches and flag %b", $time,
				outcome, {uart_w, can_w, flag});
		end
		$display("test finished at %0t", $time);
	endtask

	task automatic reg_rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge clock);
		bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic reg_wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clock);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	// status read masked to the flag, then read data must fall back to zero
	task automatic chk_status(input logic exp);
		reg_rd(`BOOT_MODE_STATUS_ADDR, d);
		chk16(d & 16'h0020, {10'h0, exp, 5'h0}, "status flag");
		@(posedge clock);
		#1;
		chk16(rdata, 16'h0, "read data after one cycle");
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 300) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (done !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: no decision", $time);
			end_sim();
		end
		#1;
	endtask

	// full reset, load flash words, raise the reset pin, wait for the decision
	task automatic boot(input logic [1:0] s, input logic [15:0] uop1, input logic ugood,
			input logic agood);
		@(posedge clock);
		nrst   <= 1'b0;
		pin    <= 1'b0;
		straps <= s;
		mem    <= {sig(16'h1234, 16'h0F0F) ^ {16{~agood}}, 16'h0F0F, 16'h1234,
			sig(16'hFFFF, uop1) ^ {16{~ugood}}, uop1, 16'hFFFF};
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		repeat (6) @(posedge clock);
		pin <= 1'b1;
		wait_done();
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		boot(`STRAP_NORMAL, 16'h0003, 1'b1, 1'b1);
		chk_boot(boot_sel_pkg::BOOT_NORMAL, 3'h0);
		chk_status(1'b0);
		boot(`STRAP_STD_BOOT, 16'h0003, 1'b1, 1'b1);
		chk_boot(boot_sel_pkg::BOOT_STANDARD, 3'h0);
		chk_status(1'b0);
		boot(2'h0, 16'h0003, 1'b1, 1'b1);
		chk_boot(boot_sel_pkg::BOOT_TEST_MODE, 3'h0);
		// user signature good, with a carry out of the sum
		boot(`STRAP_ALT_BOOT, 16'h0003, 1'b1, 1'b0);
		chk_boot(boot_sel_pkg::BOOT_ALT_USER, 3'h1);
		chk_status(1'b1);
		reg_wr(`BOOT_MODE_STATUS_ADDR, 16'h0000);
		chk_status(1'b1);
		reg_rd(16'h1234, d);
		chk16(d, 16'h0, "unmapped read");
		// a later pin edge with new straps changes nothing
		@(posedge clock);
		straps <= `STRAP_NORMAL;
		pin    <= 1'b0;
		repeat (6) @(posedge clock);
		pin <= 1'b1;
		repeat (12) @(posedge clock);
		#1;
		chk_boot(boot_sel_pkg::BOOT_ALT_USER, 3'h1);
		// software reset reruns from the latched straps
		@(posedge clock);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		#1;
		chk16({15'h0, done}, 16'h0, "done after soft reset");
		chk16({15'h0, flag}, 16'h0, "flag after soft reset");
		wait_done();
		chk_boot(boot_sel_pkg::BOOT_ALT_USER, 3'h1);
		// slow flash, alternate signature only
		@(posedge clock);
		delay <= 4'h9;
		boot(`STRAP_ALT_BOOT, 16'h0003, 1'b0, 1'b1);
		chk_boot(boot_sel_pkg::BOOT_ALT_ALT, 3'h1);
		@(posedge clock);
		delay <= 4'h2;
		// selective words: both blank values, two with a nonzero upper byte, 0002, and 0004 for the loop
		for (int i = 0; i < 6; i++) begin
			boot(`STRAP_ALT_BOOT, SEL_WORD[i], 1'b0, 1'b0);
			chk_boot(SEL_OUT[i], SEL_WF[i]);
			reg_rd(`BOOT_SEL_RESULT_ADDR, d);
			chk16(d, {8'h00, 1'b1, SEL_WF[i][1], SEL_WF[i][2], 2'h0, SEL_OUT[i]}, "result");
		end
		end_sim();
	end
endmodule
